/* verilog/scs_pkg.sv */
// constants, register map and source encodings for the serial clock source selector
package scs_pkg;

  localparam logic [4:0] OFS_CTRL     = 5'h00;
  localparam logic [4:0] OFS_EXT_MODE = 5'h04;
  localparam logic [4:0] OFS_SCM      = 5'h08;
  localparam logic [4:0] OFS_DIV      = 5'h0C;
  localparam logic [4:0] OFS_STATUS   = 5'h10;

  localparam int CTRL_CKE_LSB  = 0;
  localparam int CTRL_SYNC_BIT = 7;
  localparam int EXT_ACS_BIT   = 0;
  localparam int EXT_BASE_CLOCK_HALF_RATE_SELECT_BIT  = 4;
  localparam int SCM_SMART_CARD_INTERFACE_SELECT_BIT  = 0;

  localparam logic [7:0] CTRL_RST     = 8'h00;
  localparam logic [7:0] EXT_MODE_RST = 8'h00;
  localparam logic [7:0] SCM_RST      = 8'h00;
  localparam logic [7:0] DIV_RST      = 8'h03;

  localparam logic [1:0] CKE_BRG_HIZ = 2'h0;
  localparam logic [1:0] CKE_BRG_OUT = 2'h1;

  localparam logic [4:0] BIT_LEN_ASYNC    = 5'h10;
  localparam logic [4:0] BIT_LEN_HALF     = 5'h08;
  localparam logic [4:0] BIT_LEN_SYNC_INT = 5'h02;
  localparam logic [4:0] BIT_LEN_SYNC_EXT = 5'h01;

  typedef enum logic [2:0] {
    SRC_BRG = 3'b001,
    SRC_PIN = 3'b010,
    SRC_TMR = 3'b100
  } scs_src_t;

  // base clock ticks per bit for the chosen mode
  function automatic logic [4:0] scs_bit_len(input logic sync, input logic ext,
                                             input logic half);
    if (sync) begin
      scs_bit_len = ext ? BIT_LEN_SYNC_EXT : BIT_LEN_SYNC_INT;
    end else begin
      scs_bit_len = half ? BIT_LEN_HALF : BIT_LEN_ASYNC;
    end
  endfunction : scs_bit_len

endpackage : scs_pkg

/* verilog/scs_pin_sync.sv */
// two-stage synchroniser with rising edge pulse for the serial clock pin
`timescale 1ns/1ps
module scs_pin_sync (
  input  wire logic clk,
  input  wire logic resetn,
  input  wire logic pin_in,
  output logic      level,
  output logic      rise
);
  logic meta_r;
  logic sync_r;
  logic prev_r;
  logic rise_r;
  logic rise_nxt;

  always_comb begin
    rise_nxt = sync_r & ~prev_r;
  end

  always_ff @(posedge clk) begin
    // the pin idles high, so a low reset value would fake a rising edge
    if (!resetn) begin
      meta_r <= 1'b1;
      sync_r <= 1'b1;
      prev_r <= 1'b1;
      rise_r <= 1'b0;
    end else begin
      meta_r <= pin_in;
      sync_r <= meta_r;
      prev_r <= sync_r;
      rise_r <= rise_nxt;
    end
  end

  assign level = prev_r;
  assign rise  = rise_r;
endmodule : scs_pin_sync

/* verilog/scs_clk_select.sv */
// serial channel clock source selection with register slave on Avalon-MM
//
// Design decisions made here: the register addresses and the Avalon-MM slave port.
`timescale 1ns/1ps
module scs_clk_select
  import scs_pkg::*;
(
  input  wire logic        clk,
  input  wire logic        resetn,
  input  wire logic [4:0]  avs_address,
  input  wire logic        avs_read,
  input  wire logic        avs_write,
  input  wire logic [31:0] avs_writedata,
  output logic [31:0]      avs_readdata,
  output logic             avs_waitrequest,
  input  wire logic        sck_in,
  output logic             sck_out,
  output logic             sck_oe_n,
  input  wire logic        cmp_match_a,
  input  wire logic        cmp_match_b,
  output logic             base_tick,
  output logic             bit_tick,
  output logic             async_mode
);

  // register group
  logic [7:0]  ctrl_r;
  logic [7:0]  ctrl_nxt;
  logic [7:0]  ext_r;
  logic [7:0]  ext_nxt;
  logic [7:0]  scm_r;
  logic [7:0]  scm_nxt;
  logic [7:0]  div_r;
  logic [7:0]  div_nxt;
  logic        wait_r;
  logic        wait_nxt;
  logic [31:0] rdata_r;
  logic [31:0] rdata_nxt;

  // clock group
  scs_src_t    src_r;
  scs_src_t    src_nxt;
  logic        drive_r;
  logic        drive_nxt;
  logic        sck_r;
  logic        sck_nxt;
  logic        async_r;
  logic        async_nxt;
  logic [7:0]  brg_cnt_r;
  logic [7:0]  brg_cnt_nxt;
  logic        tmr_and_r;
  logic        tmr_and_nxt;
  logic        base_r;
  logic        base_nxt;
  logic [4:0]  phase_r;
  logic [4:0]  phase_nxt;
  logic        bit_r;
  logic        bit_nxt;

  logic        pin_level;
  logic        pin_rise;
  logic [1:0]  cke;
  logic        sync_mode;
  logic        smart_card_interface_select;
  logic        acs;
  logic        half;
  logic [4:0]  bit_len;
  logic        brg_pulse;
  logic        tmr_rise;

  scs_pin_sync u_pin_sync (
    .clk    (clk),
    .resetn (resetn),
    .pin_in (sck_in),
    .level  (pin_level),
    .rise   (pin_rise)
  );

  assign cke       = ctrl_r[CTRL_CKE_LSB +: 2];
  assign sync_mode = ctrl_r[CTRL_SYNC_BIT];
  assign smart_card_interface_select      = scm_r[SCM_SMART_CARD_INTERFACE_SELECT_BIT];
  assign acs       = ext_r[EXT_ACS_BIT];
  assign half      = ext_r[EXT_BASE_CLOCK_HALF_RATE_SELECT_BIT];

  // bus slave: every access answers one cycle after it is seen
  // a write lands only at the answer edge, the one where the master sees
  // waitrequest low, so a master that drops out early changes nothing
  always_comb begin
    ctrl_nxt  = ctrl_r;
    ext_nxt   = ext_r;
    scm_nxt   = scm_r;
    div_nxt   = div_r;
    rdata_nxt = rdata_r;
    wait_nxt  = 1'b1;
    if (avs_write && !wait_r) begin
      unique case (avs_address)
        OFS_CTRL:     ctrl_nxt = avs_writedata[7:0];
        OFS_EXT_MODE: ext_nxt  = avs_writedata[7:0];
        OFS_SCM:      scm_nxt  = avs_writedata[7:0];
        OFS_DIV:      div_nxt  = avs_writedata[7:0];
        default:      ;
      endcase
    end
    // read data is captured when the request is seen and stands in the answer cycle
    if ((avs_read || avs_write) && wait_r) begin
      wait_nxt  = 1'b0;
      if (avs_read) begin
        unique case (avs_address)
          OFS_CTRL:     rdata_nxt = {24'h000000, ctrl_r};
          OFS_EXT_MODE: rdata_nxt = {24'h000000, ext_r};
          OFS_SCM:      rdata_nxt = {24'h000000, scm_r};
          OFS_DIV:      rdata_nxt = {24'h000000, div_r};
          OFS_STATUS:   rdata_nxt = {24'h000000, 2'h0, pin_level, async_r,
                                     ~drive_r, src_r};
          default:      rdata_nxt = 32'h0000_0000;
        endcase
      end
    end
  end

  always_ff @(posedge clk) begin
    if (!resetn) begin
      ctrl_r  <= CTRL_RST;
      ext_r   <= EXT_MODE_RST;
      scm_r   <= SCM_RST;
      div_r   <= DIV_RST;
      wait_r  <= 1'b1;
      rdata_r <= 32'h0000_0000;
    end else begin
      ctrl_r  <= ctrl_nxt;
      ext_r   <= ext_nxt;
      scm_r   <= scm_nxt;
      div_r   <= div_nxt;
      wait_r  <= wait_nxt;
      rdata_r <= rdata_nxt;
    end
  end

  // source choice and pin direction
  always_comb begin
    async_nxt = ~sync_mode & ~smart_card_interface_select;
    src_nxt   = SRC_BRG;
    drive_nxt = 1'b0;
    if (sync_mode && !smart_card_interface_select) begin
      if (!cke[1]) begin
        drive_nxt = 1'b1;
      end else begin
        src_nxt = SRC_PIN;
      end
    end else if (!smart_card_interface_select) begin
      if (cke == CKE_BRG_HIZ) begin
        drive_nxt = 1'b0;
      end else if (cke == CKE_BRG_OUT) begin
        drive_nxt = 1'b1;
      end else begin
        // select bit only looked at here
        src_nxt = acs ? SRC_TMR : SRC_PIN;
        drive_nxt = 1'b0;
      end
    end
  end

  // base and bit tick generation
  assign bit_len   = scs_bit_len(sync_mode, src_r == SRC_PIN, half);
  assign brg_pulse = (brg_cnt_r == 8'h00);
  assign tmr_rise  = cmp_match_a & cmp_match_b & ~tmr_and_r;

  always_comb begin
    brg_cnt_nxt = brg_pulse ? div_r : brg_cnt_r - 8'h01;
    tmr_and_nxt = cmp_match_a & cmp_match_b;
    unique case (src_r)
      SRC_BRG: base_nxt = brg_pulse;
      SRC_PIN: base_nxt = pin_rise;
      SRC_TMR: base_nxt = tmr_rise;
      default: base_nxt = 1'b0;
    endcase
    phase_nxt = phase_r;
    bit_nxt   = 1'b0;
    if (src_nxt != src_r || phase_r >= bit_len) begin
      phase_nxt = 5'h00;
    end else if (base_r) begin
      if (phase_r == bit_len - 5'h01) begin
        phase_nxt = 5'h00;
        bit_nxt   = 1'b1;
      end else begin
        phase_nxt = phase_r + 5'h01;
      end
    end
    // driven clock has the bit rate: low first half, high second half
    sck_nxt = drive_r ? (phase_r >= (bit_len >> 1)) : 1'b1;
  end

  always_ff @(posedge clk) begin
    if (!resetn) begin
      src_r     <= SRC_BRG;
      drive_r   <= 1'b0;
      sck_r     <= 1'b1;
      async_r   <= 1'b1;
      brg_cnt_r <= 8'h00;
      tmr_and_r <= 1'b0;
      base_r    <= 1'b0;
      phase_r   <= 5'h00;
      bit_r     <= 1'b0;
    end else begin
      src_r     <= src_nxt;
      drive_r   <= drive_nxt;
      sck_r     <= sck_nxt;
      async_r   <= async_nxt;
      brg_cnt_r <= brg_cnt_nxt;
      tmr_and_r <= tmr_and_nxt;
      base_r    <= base_nxt;
      phase_r   <= phase_nxt;
      bit_r     <= bit_nxt;
    end
  end

  assign avs_readdata    = rdata_r;
  assign avs_waitrequest = wait_r;
  assign sck_out         = sck_r;
  assign sck_oe_n        = ~drive_r;
  assign base_tick       = base_r;
  assign bit_tick        = bit_r;
  assign async_mode      = async_r;

  default clocking cb @(posedge clk); endclocking
  default disable iff (!resetn);

  smart_card_interface_select_not_async_a: assert property (smart_card_interface_select |=> !async_mode)
    else $error("smart card select did not leave async mode");
  smart_card_interface_select_brg_hiz_a: assert property (smart_card_interface_select |=> sck_oe_n && src_r == SRC_BRG)
    else $error("smart card select did not float the pin on the baud generator");
  async00_hiz_a: assert property (!sync_mode && !smart_card_interface_select && cke == 2'h0
    |=> sck_oe_n && src_r == SRC_BRG)
    else $error("enable 00 did not float the pin on the baud generator");
  async01_drive_a: assert property (!sync_mode && !smart_card_interface_select && cke == 2'h1
    |=> !sck_oe_n && src_r == SRC_BRG)
    else $error("enable 01 did not drive the pin");
  float_pin_high_a: assert property (sck_oe_n ##1 sck_oe_n |-> sck_out)
    else $error("pin output value not high while floated");
  brg_tick_a: assert property (src_r == SRC_BRG && brg_pulse |=> base_tick)
    else $error("baud generator pulse gave no base tick");
  async_len_a: assert property (!sync_mode && !half |-> bit_len == 5'h10)
    else $error("async bit not sixteen base ticks");
  bit_after_base_a: assert property (bit_tick |-> $past(base_tick))
    else $error("bit tick without a base tick before it");
  half_len_a: assert property (!sync_mode && half |-> bit_len == 5'h08)
    else $error("half rate did not give eight ticks per bit");
  timer_hiz_a: assert property (src_r == SRC_TMR |-> sck_oe_n)
    else $error("pin driven while timer clock in use");
  sync_int_drive_a: assert property (sync_mode && !smart_card_interface_select && !cke[1] |=> !sck_oe_n)
    else $error("synchronous internal clock not driven");
  sync_ext_input_a: assert property (sync_mode && !smart_card_interface_select && cke[1]
    |=> sck_oe_n && src_r == SRC_PIN)
    else $error("synchronous external clock pin not an input");
  sync_len_a: assert property (sync_mode && src_r == SRC_BRG |-> bit_len == 5'h02)
    else $error("synchronous internal bit not two base ticks");
  pin_source_a: assert property (!sync_mode && !smart_card_interface_select && cke[1] && !acs
    |=> src_r == SRC_PIN)
    else $error("select bit zero did not choose the pin clock");
  sync_acs_ignored_a: assert property (sync_mode && !smart_card_interface_select && cke[1] && acs
    |=> src_r == SRC_PIN)
    else $error("select bit acted in synchronous mode");
  pin_tick_a: assert property (src_r == SRC_PIN && pin_rise |=> base_tick)
    else $error("pin rising edge gave no base tick");
  timer_source_a: assert property (!sync_mode && !smart_card_interface_select && cke[1] && acs
    |=> src_r == SRC_TMR)
    else $error("select bit one did not choose the timer clock");
  timer_tick_a: assert property (src_r == SRC_TMR && tmr_rise |=> base_tick)
    else $error("timer match rise gave no base tick");
  timer_and_gate_a: assert property (src_r == SRC_TMR && !(cmp_match_a && cmp_match_b)
    |=> !base_tick)
    else $error("base tick without both compare matches");
  select_ignored_a: assert property (!cke[1] |=> src_r != SRC_TMR)
    else $error("timer clock chosen without enable 1x");
  bus_answer_a: assert property ((avs_read || avs_write) && avs_waitrequest
    |=> !avs_waitrequest ##1 avs_waitrequest)
    else $error("bus answer not exactly one cycle long");
  write_land_a: assert property (avs_write && !avs_waitrequest && avs_address == OFS_CTRL
    |=> ctrl_r == $past(avs_writedata[7:0]))
    else $error("control write did not land at the answer edge");

endmodule : scs_clk_select

/* tb/scs_sck_partner.sv */
// external clock source that feeds the serial clock pin
`timescale 1ns/1ps
module scs_sck_partner #(
  parameter int HALF = 3
) (
  input  wire logic clk,
  input  wire logic run,
  output logic      sck
);
  int cnt_r = 0;
  initial sck = 1'b1;
  // free clock only while the device floats the pin; stands still high otherwise
  always @(posedge clk) begin
    if (!run) begin
      cnt_r <= 0;
      sck <= 1'b1;
    end else if (cnt_r == HALF - 1) begin
      cnt_r <= 0;
      sck <= !sck;
    end else begin
      cnt_r <= cnt_r + 1;
    end
  end
endmodule : scs_sck_partner

/* tb/tb_scs_clk_select.sv */
// self-checking bench for the serial clock source selector
`timescale 1ns/1ps
module tb_scs_clk_select;
  import scs_pkg::*;
  logic        clk = 1'b0;
  logic        resetn = 1'b0;
  logic [4:0]  avs_address = 5'h00;
  logic        avs_read = 1'b0;
  logic        avs_write = 1'b0;
  logic [31:0] avs_writedata = 32'h0;
  logic        cmp_match_a = 1'b0;
  logic        cmp_match_b = 1'b0;
  logic [31:0] avs_readdata, q;
  logic        avs_waitrequest, sck_out, sck_oe_n, p_sck, sck_in;
  logic        base_tick, bit_tick, async_mode;
  int          err_count = 0;
  int          checked = 0;
  int          bt_n = 0;
  // pin level: device when enabled, else the partner
  assign sck_in = sck_oe_n ? p_sck : sck_out;
  always #12.5 clk = ~clk;
  always @(posedge clk) if (base_tick === 1'b1) bt_n <= bt_n + 1;
  scs_clk_select i_scs_clk_select (.clk(clk), .resetn(resetn), .avs_address(avs_address),
    .avs_read(avs_read), .avs_write(avs_write), .avs_writedata(avs_writedata),
    .avs_readdata(avs_readdata), .avs_waitrequest(avs_waitrequest), .sck_in(sck_in),
    .sck_out(sck_out), .sck_oe_n(sck_oe_n), .cmp_match_a(cmp_match_a),
    .cmp_match_b(cmp_match_b), .base_tick(base_tick), .bit_tick(bit_tick),
    .async_mode(async_mode));
  scs_sck_partner #(.HALF(3)) i_scs_sck_partner (.clk(clk), .run(sck_oe_n), .sck(p_sck));
  task automatic wrap_up();
    $display("checks %0d errors %0d", checked, err_count);
    if (err_count == 0 && checked > 0) $display("Run complete: PASS");
    else $display("Run complete: FAIL");
    $finish;
  endtask : wrap_up
  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    checked++;
    if (got !== exp) begin
      err_count++;
      $display("Error t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask : chk
  task automatic bus(input logic w, input logic [4:0] a, input logic [7:0] d);
    int n;
    n = 0;
    @(posedge clk);
    avs_address <= a;
    avs_writedata <= {24'h0, d};
    avs_write <= w;
    avs_read <= !w;
    do begin
      @(posedge clk);
      n++;
    end while (avs_waitrequest !== 1'b0 && n < 20);
    q = avs_readdata;
    avs_write <= 1'b0;
    avs_read <= 1'b0;
    if (avs_waitrequest !== 1'b0) begin
      err_count++;
      wrap_up();
    end
  endtask : bus
  task automatic wt(output int n);
    n = 0;
    do begin
      @(posedge clk);
      n++;
    end while (bit_tick !== 1'b1 && n < 400);
    if (n >= 400) begin
      err_count++;
      wrap_up();
    end
  endtask : wt
  // cycles between bit ticks, after letting the mode settle
  task automatic per(input int exp);
    int n;
    wt(n);
    wt(n);
    wt(n);
    chk(n, exp);
  endtask : per
  // driven pin clock over one bit period: half of it high, one rising edge
  task automatic sckp(input int len);
    int hi, ed, n;
    logic pv;
    wt(n);
    hi = 0;
    ed = 0;
    pv = sck_out;
    repeat (len) begin
      @(posedge clk);
      hi += (sck_out === 1'b1);
      ed += (sck_out === 1'b1 && pv === 1'b0);
      pv = sck_out;
    end
    chk(hi, len / 2);
    chk(ed, 1);
  endtask : sckp
  task automatic setm(input logic [7:0] c, input logic [7:0] e, input logic [7:0] s);
    bus(1'b1, OFS_EXT_MODE, e);
    bus(1'b1, OFS_SCM, s);
    bus(1'b1, OFS_CTRL, c);
    repeat (3) @(posedge clk);
  endtask : setm
  task automatic pins(input logic [2:0] src, input logic oe, input logic am);
    bus(1'b0, OFS_STATUS, 8'h00);
    chk(q & 32'h1F, {27'h0, am, oe, src});
    chk({31'h0, sck_oe_n}, {31'h0, oe});
    chk({31'h0, async_mode}, {31'h0, am});
    if (oe) chk({31'h0, sck_out}, 32'h1);
  endtask : pins
  task automatic t_reset();
    bus(1'b0, OFS_CTRL, 8'h00);
    chk(q, {24'h0, CTRL_RST});
    bus(1'b0, OFS_EXT_MODE, 8'h00);
    chk(q, {24'h0, EXT_MODE_RST});
    bus(1'b0, OFS_SCM, 8'h00);
    chk(q, {24'h0, SCM_RST});
    bus(1'b0, OFS_DIV, 8'h00);
    chk(q, {24'h0, DIV_RST});
    bus(1'b1, 5'h14, 8'hFF);
    bus(1'b0, 5'h14, 8'h00);
    chk(q, 32'h0);
    pins(SRC_BRG, 1'b1, 1'b1);
  endtask : t_reset
  task automatic t_brg();
    setm(8'h00, 8'h01, 8'h00);
    pins(SRC_BRG, 1'b1, 1'b1);
    setm(8'h01, 8'h00, 8'h00);
    pins(SRC_BRG, 1'b0, 1'b1);
    per(64);
    sckp(64);
  endtask : t_brg
  task automatic t_pin();
    setm(8'h02, 8'h00, 8'h00);
    pins(SRC_PIN, 1'b1, 1'b1);
    per(96);
    setm(8'h03, 8'h10, 8'h00);
    per(48);
  endtask : t_pin
  task automatic t_tmr();
    setm(8'h02, 8'h01, 8'h00);
    pins(SRC_TMR, 1'b1, 1'b1);
    @(posedge clk) cmp_match_a <= 1'b1;
    repeat (5) @(posedge clk);
    bt_n = 0;
    repeat (10) @(posedge clk);
    chk(bt_n, 0);
    repeat (4) begin
      @(posedge clk) cmp_match_b <= 1'b1;
      repeat (3) @(posedge clk);
      cmp_match_b <= 1'b0;
      repeat (3) @(posedge clk);
    end
    repeat (4) @(posedge clk);
    chk(bt_n, 4);
    cmp_match_a <= 1'b0;
  endtask : t_tmr
  task automatic t_sync();
    setm(8'h80, 8'h00, 8'h00);
    pins(SRC_BRG, 1'b0, 1'b0);
    per(8);
    sckp(8);
    setm(8'h81, 8'h00, 8'h00);
    pins(SRC_BRG, 1'b0, 1'b0);
    bus(1'b0, OFS_CTRL, 8'h00);
    chk(q, 32'h81);
    setm(8'h82, 8'h00, 8'h00);
    pins(SRC_PIN, 1'b1, 1'b0);
    per(6);
    setm(8'h83, 8'h01, 8'h00);
    pins(SRC_PIN, 1'b1, 1'b0);
  endtask : t_sync
  task automatic t_smart_card_interface_select();
    setm(8'h01, 8'h00, 8'h01);
    pins(SRC_BRG, 1'b1, 1'b0);
  endtask : t_smart_card_interface_select
  initial begin
    repeat (16) @(posedge clk);
    resetn <= 1'b1;
    t_reset();
    t_brg();
    t_pin();
    t_tmr();
    t_sync();
    t_smart_card_interface_select();
    wrap_up();
  end
  initial begin
    #2000000;
    err_count++;
    wrap_up();
  end
endmodule : tb_scs_clk_select
